// [verilog/pecd_top.sv]
// Local design decisions: the strobed register port and the register offsets.
`include "pecd_map.svh"
module pecd_top #(
   parameter bit HAS_PORT_C = 1'b1
) (
   // clock and reset
   input  wire logic                 clk_in,
   input  wire logic                 srst_in,
   // pins
   input  wire pecd_pkg::pecd_pins_t port_a_pin_n_in,
   input  wire pecd_pkg::pecd_pins_t port_c_pin_n_in,
   // register port
   input  wire pecd_pkg::pecd_bus_req_t bus_in,
   output logic [7:0]                rdata_out,
   // events
   output logic                      aggregate_change_event_out,
   output logic                      wake_out,
   output logic                      irq_out
);
   import pecd_pkg::*;

   pecd_pins_t a_rise;
   pecd_pins_t a_fall;
   pecd_pins_t a_flags;
   pecd_pins_t c_rise;
   pecd_pins_t c_fall;
   pecd_pins_t c_flags;
   pecd_pins_t c_rise_q;
   pecd_pins_t c_fall_q;
   pecd_pins_t c_flags_q;
   pecd_pins_t c_pins;
   pecd_pins_t wdata6;
   logic       a_hit;
   logic       c_hit;
   logic       c_hit_q;
   logic       any_hit;
   logic       change_module_irq_enable;
   logic [1:0] irq_stat;
   logic [1:0] irq_mask;
   logic [1:0] stat_set;
   logic [7:0] next_rdata;
   logic       agg;

   // bits seven and six are dropped on write
   assign wdata6 = bus_in.wdata[`PECD_PIN_MSB:0];
   // smaller variant: port C pins tied low so nothing can ever fire
   assign c_pins = HAS_PORT_C ? port_c_pin_n_in : `PECD_RST_PINS;

   pecd_port u_port_a (
      .clk_in      (clk_in),
      .srst_in     (srst_in),
      .pins_in     (port_a_pin_n_in),
      .rise_we_in  (bus_in.wr && bus_in.addr == `PECD_OFF_A_RISE),
      .fall_we_in  (bus_in.wr && bus_in.addr == `PECD_OFF_A_FALL),
      .flag_we_in  (bus_in.wr && bus_in.addr == `PECD_OFF_A_FLAGS),
      .wdata_in    (wdata6),
      .rise_en_out (a_rise),
      .fall_en_out (a_fall),
      .flags_out   (a_flags),
      .hit_out     (a_hit)
   );

   pecd_port u_port_c (
      .clk_in      (clk_in),
      .srst_in     (srst_in),
      .pins_in     (c_pins),
      .rise_we_in  (HAS_PORT_C && bus_in.wr && bus_in.addr == `PECD_OFF_C_RISE),
      .fall_we_in  (HAS_PORT_C && bus_in.wr && bus_in.addr == `PECD_OFF_C_FALL),
      .flag_we_in  (HAS_PORT_C && bus_in.wr && bus_in.addr == `PECD_OFF_C_FLAGS),
      .wdata_in    (wdata6),
      .rise_en_out (c_rise_q),
      .fall_en_out (c_fall_q),
      .flags_out   (c_flags_q),
      .hit_out     (c_hit_q)
   );

   // absent port C reads as zero everywhere
   assign c_rise  = HAS_PORT_C ? c_rise_q  : `PECD_RST_PINS;
   assign c_fall  = HAS_PORT_C ? c_fall_q  : `PECD_RST_PINS;
   assign c_flags = HAS_PORT_C ? c_flags_q : `PECD_RST_PINS;
   assign c_hit   = HAS_PORT_C ? c_hit_q   : 1'b0;
   assign any_hit = a_hit | c_hit;

   // aggregate follows the flags: set with any flag, clear only when all clear
   assign agg = (|a_flags) | (|c_flags);

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         change_module_irq_enable <= 1'b0;
      end else if (bus_in.wr && bus_in.addr == `PECD_OFF_CTRL) begin
         change_module_irq_enable <= bus_in.wdata[`PECD_CTRL_IRQ_EN];
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         irq_mask <= `PECD_RST_STAT;
      end else if (bus_in.wr && bus_in.addr == `PECD_OFF_IRQ_MASK) begin
         irq_mask <= bus_in.wdata[1:0];
      end
   end

   // status: aggregate seen and wake seen; hardware set beats write-one clear
   assign stat_set[`PECD_STAT_AGG]  = any_hit;
   assign stat_set[`PECD_STAT_WAKE] = any_hit & change_module_irq_enable;

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         irq_stat <= `PECD_RST_STAT;
      end else if (bus_in.wr && bus_in.addr == `PECD_OFF_IRQ_STAT) begin
         irq_stat <= (irq_stat & ~bus_in.wdata[1:0]) | stat_set;
      end else begin
         irq_stat <= irq_stat | stat_set;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         aggregate_change_event_out <= 1'b0;
      end else begin
         // hit folds into the flag the same edge, so the event never lags a flag set by an edge
         aggregate_change_event_out <= agg | any_hit;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         wake_out <= 1'b0;
      end else begin
         // detection runs regardless; only the request to the core is gated
         wake_out <= change_module_irq_enable & (agg | any_hit);
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |((irq_stat | stat_set) & irq_mask);
      end
   end

   always_comb begin
      next_rdata = `PECD_RST_BYTE;
      unique case (bus_in.addr)
         `PECD_OFF_A_RISE:   next_rdata = {2'b00, a_rise};
         `PECD_OFF_A_FALL:   next_rdata = {2'b00, a_fall};
         `PECD_OFF_A_FLAGS:  next_rdata = {2'b00, a_flags};
         `PECD_OFF_C_RISE:   next_rdata = {2'b00, c_rise};
         `PECD_OFF_C_FALL:   next_rdata = {2'b00, c_fall};
         `PECD_OFF_C_FLAGS:  next_rdata = {2'b00, c_flags};
         `PECD_OFF_CTRL:     next_rdata = {7'h00, change_module_irq_enable};
         `PECD_OFF_IRQ_STAT: next_rdata = {6'h00, irq_stat};
         `PECD_OFF_IRQ_MASK: next_rdata = {6'h00, irq_mask};
         default:            next_rdata = `PECD_RST_BYTE;
      endcase
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         rdata_out <= `PECD_RST_BYTE;
      end else if (bus_in.rd) begin
         rdata_out <= next_rdata;
      end else begin
         rdata_out <= `PECD_RST_BYTE;
      end
   end
endmodule // pecd_top

// [verilog/pecd_map.svh]
`ifndef PECD_MAP_SVH
`define PECD_MAP_SVH
// register offsets, plain byte-wide port
`define PECD_OFF_A_RISE     8'h00
`define PECD_OFF_A_FALL     8'h01
`define PECD_OFF_A_FLAGS    8'h02
`define PECD_OFF_C_RISE     8'h03
`define PECD_OFF_C_FALL     8'h04
`define PECD_OFF_C_FLAGS    8'h05
`define PECD_OFF_CTRL       8'h06
`define PECD_OFF_IRQ_STAT   8'h07
`define PECD_OFF_IRQ_MASK   8'h08
// field positions
`define PECD_PIN_MSB        5
`define PECD_CTRL_IRQ_EN    0
`define PECD_STAT_AGG       0
`define PECD_STAT_WAKE      1
// reset values
`define PECD_RST_PINS       6'h00
`define PECD_RST_BYTE       8'h00
`define PECD_RST_STAT       2'h0
`endif

// [verilog/pecd_pkg.sv]
package pecd_pkg;
   typedef logic [5:0] pecd_pins_t;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } pecd_bus_req_t;
endpackage : pecd_pkg

// [verilog/pecd_port.sv]
`include "pecd_map.svh"
// one six-pin port: synchroniser, edge detect, enables and sticky flags
module pecd_port (
   // clock and reset
   input  wire logic             clk_in,
   input  wire logic             srst_in,
   // pins
   input  wire pecd_pkg::pecd_pins_t pins_in,
   // software access
   input  wire logic             rise_we_in,
   input  wire logic             fall_we_in,
   input  wire logic             flag_we_in,
   input  wire pecd_pkg::pecd_pins_t wdata_in,
   // state
   output pecd_pkg::pecd_pins_t  rise_en_out,
   output pecd_pkg::pecd_pins_t  fall_en_out,
   output pecd_pkg::pecd_pins_t  flags_out,
   output logic                  hit_out
);
   import pecd_pkg::*;

   pecd_pins_t sync1;
   pecd_pins_t sync2;
   pecd_pins_t prev;
   pecd_pins_t hit;

   // chain stays out of reset: a pin held high across reset gives no false edge on release
   always_ff @(posedge clk_in) begin
      // second stage only reads the first; edges compare stages two and three
      sync1 <= pins_in;
      sync2 <= sync1;
      prev  <= sync2;
   end

   // both enables zero means no hit at all
   assign hit = (rise_en_out & sync2 & ~prev)
              | (fall_en_out & ~sync2 & prev)
              ;
   assign hit_out = |hit;

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         rise_en_out <= `PECD_RST_PINS;
         fall_en_out <= `PECD_RST_PINS;
      end else begin
         if (rise_we_in) begin
            rise_en_out <= wdata_in;
         end
         if (fall_we_in) begin
            fall_en_out <= wdata_in;
         end
      end
   end

   // a write may clear or set; a coincident edge always wins
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         flags_out <= `PECD_RST_PINS;
      end else if (flag_we_in) begin
         flags_out <= wdata_in | hit;
      end else begin
         flags_out <= flags_out | hit;
      end
   end
endmodule // pecd_port

// [test/pecd_top_properties.sv]
module pecd_top_properties #(
   parameter bit HAS_PORT_C = 1'b1
) (
   input wire logic                    clk_in,
   input wire logic                    srst_in,
   input wire pecd_pkg::pecd_pins_t    port_a_pin_n_in,
   input wire pecd_pkg::pecd_pins_t    port_c_pin_n_in,
   input wire pecd_pkg::pecd_bus_req_t bus_in,
   input wire logic [7:0]              rdata_out,
   input wire logic                    aggregate_change_event_out,
   input wire logic                    wake_out,
   input wire logic                    irq_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import pecd_pkg::*;
   wire logic agg;
   assign agg = aggregate_change_event_out;
   default clocking @(posedge clk_in); endclocking
   default disable iff (srst_in);
   a_pin_upper: assert property (bus_in.rd && bus_in.addr < 8'h06 |=> rdata_out[7:6] == 2'h0)
      else $error("upper pin bits read nonzero");
   a_reset_zero: assert property ($past(srst_in) |-> !agg && !wake_out && !irq_out && rdata_out == 8'h00)
      else $error("outputs not clear after reset");
   a_agg_stays: assert property (agg && !bus_in.wr && !$past(bus_in.wr) |=> agg)
      else $error("event dropped without a write");
   a_agg_clear: assert property ($fell(agg) |-> $past(bus_in.wr, 2) || $past(srst_in))
      else $error("event fell without a flag write");
   // a settled pin with no write can never raise the event, however enabled
   a_quiet_pins: assert property ((!agg && $stable(port_a_pin_n_in) && $stable(port_c_pin_n_in)
      && !bus_in.wr) [*3] |=> !agg)
      else $error("event raised with pins quiet");
   a_wake_agg: assert property (wake_out |-> agg)
      else $error("wake without event");
   a_flag_or: assert property (bus_in.rd && bus_in.addr == 8'h02 ##1 rdata_out[5:0] != 6'h00 |-> agg)
      else $error("flag set but event low");
   a_c_hidden: assert property (!HAS_PORT_C && bus_in.rd && bus_in.addr inside {[8'h03:8'h05]}
      |=> rdata_out == 8'h00)
      else $error("port c visible on small variant");
   c_agg: cover property ($rose(agg));
   c_wake: cover property ($rose(wake_out));
   c_irq: cover property ($rose(irq_out));
endmodule // pecd_top_properties

bind pecd_top pecd_top_properties #(.HAS_PORT_C(HAS_PORT_C)) pecd_top_properties_inst (
   .clk_in(clk_in), .srst_in(srst_in), .port_a_pin_n_in(port_a_pin_n_in),
   .port_c_pin_n_in(port_c_pin_n_in), .bus_in(bus_in), .rdata_out(rdata_out),
   .aggregate_change_event_out(aggregate_change_event_out), .wake_out(wake_out), .irq_out(irq_out));

// [test/pecd_pin_drv.sv]
// outside world on the pins: levels move only just after an edge
module pecd_pin_drv (
   input  wire logic           clk_in,
   input  wire pecd_pkg::pecd_pins_t a_in,
   input  wire pecd_pkg::pecd_pins_t c_in,
   output pecd_pkg::pecd_pins_t a_out = '0,
   output pecd_pkg::pecd_pins_t c_out = '0
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge clk_in) begin
      a_out <= a_in;
      c_out <= c_in;
   end
endmodule // pecd_pin_drv

// [test/pecd_top_tb_top.sv]
module pecd_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import pecd_pkg::*;
   logic          clk_in = 1'b0;
   logic          srst_in = 1'b1;
   pecd_bus_req_t bus = '0;
   pecd_pins_t    a_next = '0, c_next = '0, pa, pc, na, nc, ra, rf, ca, cf, ea, ec;
   logic [7:0]    rdata, rdata_s, ctl, msk;
   logic          agg, wake, irq, any;
   int            errors = 0, compares = 0, seed = 83882;
   always #5 clk_in = ~clk_in;
   pecd_pin_drv pecd_pin_drv_inst (.clk_in(clk_in), .a_in(a_next), .c_in(c_next), .a_out(pa), .c_out(pc));
   pecd_top pecd_top_inst (.clk_in(clk_in), .srst_in(srst_in), .port_a_pin_n_in(pa), .port_c_pin_n_in(pc),
      .bus_in(bus), .rdata_out(rdata), .aggregate_change_event_out(agg), .wake_out(wake), .irq_out(irq));
   pecd_top #(.HAS_PORT_C(1'b0)) pecd_top_small_inst (.clk_in(clk_in), .srst_in(srst_in),
      .port_a_pin_n_in(pa), .port_c_pin_n_in(pc), .bus_in(bus), .rdata_out(rdata_s),
      .aggregate_change_event_out(), .wake_out(), .irq_out());
   function automatic pecd_pins_t edges(pecd_pins_t o, n, r, f);
      return (r & ~o & n) | (f & o & ~n);
   endfunction
   task automatic chk(input logic [7:0] got, exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge clk_in) bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk_in) bus <= '0;
   endtask
   task automatic rd(input logic [7:0] a, e);
      @(posedge clk_in) bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk_in) bus <= '0;
      #1 chk(rdata, e);
      if (a < 8'h06) chk(rdata_s, a > 8'h02 ? 8'h00 : e);
   endtask
   task automatic complete_run;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk_in);
      srst_in <= 1'b0;
      for (int i = 0; i < 10; i++) rd(8'(i), 8'h00);
      for (int i = 0; i < 6; i++) begin
         wr(8'(i), 8'hff);
         rd(8'(i), 8'h3f);
      end
      chk(8'(agg), 8'h01);
      for (int i = 0; i < 6; i++) wr(8'(i), 8'h00);
      // the event register follows the cleared flags one edge later
      @(posedge clk_in);
      #1 chk(8'(agg), 8'h00);
      $display("test registers done");
      for (int i = 0; i < 20; i++) begin
         {ra, rf, ca, cf} = 24'($random(seed));
         if (i < 2) {ra, rf, ca, cf} = i ? '1 : '0;
         ctl = 8'($random(seed)) & 8'h01;
         msk = 8'($random(seed)) & 8'h03;
         wr(8'h00, {2'b11, ra});
         wr(8'h01, {2'b11, rf});
         wr(8'h03, {2'b11, ca});
         wr(8'h04, {2'b11, cf});
         wr(8'h02, 8'h00);
         wr(8'h05, 8'h00);
         wr(8'h07, 8'h03);
         wr(8'h08, msk);
         wr(8'h06, ctl);
         {na, nc} = 12'($random(seed));
         ea = edges(pa, na, ra, rf);
         ec = edges(pc, nc, ca, cf);
         any = |{ea, ec};
         a_next <= na;
         c_next <= nc;
         repeat (6) @(posedge clk_in);
         rd(8'h02, {2'b00, ea});
         rd(8'h05, {2'b00, ec});
         rd(8'h07, {6'h00, ctl[0] & any, any});
         chk(8'(agg), 8'(any));
         chk(8'(wake), 8'(ctl[0] & any));
         chk(8'(irq), 8'(any & (msk[0] | (msk[1] & ctl[0]))));
      end
      $display("test random edges done");
      wr(8'h00, 8'h01);
      a_next <= '0;
      repeat (6) @(posedge clk_in);
      wr(8'h02, 8'h00);
      a_next <= 6'h01;
      repeat (2) @(posedge clk_in);
      // this write lands on the very edge that records the rise
      wr(8'h02, 8'h00);
      rd(8'h02, 8'h01);
      wr(8'h02, 8'h00);
      rd(8'h02, 8'h00);
      @(posedge clk_in) srst_in <= 1'b1;
      @(posedge clk_in) srst_in <= 1'b0;
      rd(8'h00, 8'h00);
      $display("test collision and reset done");
      complete_run;
   end
   initial begin
      #50000;
      errors++;
      complete_run;
   end
endmodule // pecd_top_tb_top
